// [pkg/ssfdb_pkg.sv]
// Purpose: shared constants and types of the serial flags and byte buffer block
// Assumes: 8-bit register port, one 25 MHz clock
// Notes: offsets are byte addresses on the plain register port
package ssfdb_pkg;

  localparam int unsigned CLK_HZ = 25000000;

  // register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_FLAGS_AND_RATE = 8'h11;
  localparam logic [7:0] OFS_BYTE_BUFFER = 8'h12;

  // control register fields
  localparam int unsigned CTL_RX_IRQ_EN = 7;
  localparam int unsigned CTL_MASTER = 5;
  localparam int unsigned CTL_CPOL = 4;
  localparam int unsigned CTL_CPHA = 3;
  localparam int unsigned CTL_ENABLE = 1;
  localparam int unsigned CTL_TX_IRQ_EN = 0;
  localparam logic [7:0] CTL_RESET = 8'h28;
  localparam logic [7:0] CTL_WMASK = 8'hBB;

  // flags and rate register fields
  localparam int unsigned FLG_RX_FULL = 7;
  localparam int unsigned FLG_ERR_IRQ_EN = 6;
  localparam int unsigned FLG_OVERRUN = 5;
  localparam int unsigned FLG_MODE_FAULT = 4;
  localparam int unsigned FLG_TX_EMPTY = 3;
  localparam int unsigned FLG_MODE_FAULT_FLAG_EN = 2;
  localparam int unsigned FLG_RATE_HI = 1;
  localparam int unsigned FLG_RATE_LO = 0;
  localparam logic [7:0] FLG_RESET = 8'h08;

  // rate divisors for select codes 00, 01, 10, 11
  localparam logic [7:0] RATE_DIV_0 = 8'h02;
  localparam logic [7:0] RATE_DIV_1 = 8'h08;
  localparam logic [7:0] RATE_DIV_2 = 8'h20;
  localparam logic [7:0] RATE_DIV_3 = 8'h80;

  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [0:0] {st_idle, st_xfer} ssfdb_state_e;

endpackage

// [logic/ssfdb_top.sv]
// Purpose: status flags, rate select and byte buffer of an 8-bit serial link
// Assumes: all pin inputs synchronous to clk; software obeys the buffer rules
// Notes: one transfer engine serves both master and slave operation
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ssfdb_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupt requests
  output logic irq_receive,
  output logic irq_transmit,
  output logic irq_error,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  // master out slave in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  // master in slave out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  // slave select pin
  input wire logic ss_n_in,
  output logic ss_gpio_release
);

  // rate select code to divisor
  function automatic logic [7:0] rate_divisor(input logic [1:0] sel);
    case (sel)
      2'b00: rate_divisor = ssfdb_pkg::RATE_DIV_0;
      2'b01: rate_divisor = ssfdb_pkg::RATE_DIV_1;
      2'b10: rate_divisor = ssfdb_pkg::RATE_DIV_2;
      default: rate_divisor = ssfdb_pkg::RATE_DIV_3;
    endcase
  endfunction

  logic [7:0] ctl_r;
  logic receive_full_flag_r;
  logic error_irq_enable_r;
  logic overrun_flag_r;
  logic mode_fault_flag_r;
  logic transmit_empty_flag_r;
  logic mode_fault_detect_enable_r;
  logic rate_select_high_r;
  logic rate_select_low_r;
  logic ovr_arm_r;
  logic mode_fault_flag_arm_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic rbit_r;
  logic out_r;
  logic phase_r;
  logic sck_r;
  logic [7:0] div_r;
  logic sck_prev_r;
  logic ss_prev_r;
  ssfdb_pkg::ssfdb_state_e st_r;

  logic enable;
  logic master;
  logic cpol;
  logic cpha;
  logic wr_ctl;
  logic wr_flg;
  logic wr_dat;
  logic rd_flg;
  logic rd_dat;
  logic tick;
  logic lead;
  logic trail;
  logic slave_edge;
  logic slave_start;
  logic active;
  logic load;
  logic done;
  logic in_bit;
  logic [7:0] byte_in;
  logic [7:0] divisor;
  logic fault_slave;
  logic fault_master;
  logic abort;

  assign enable = ctl_r[ssfdb_pkg::CTL_ENABLE];
  assign master = ctl_r[ssfdb_pkg::CTL_MASTER];
  assign cpol = ctl_r[ssfdb_pkg::CTL_CPOL];
  assign cpha = ctl_r[ssfdb_pkg::CTL_CPHA];

  assign wr_ctl = reg_wr && (reg_addr == ssfdb_pkg::OFS_CONTROL);
  assign wr_flg = reg_wr && (reg_addr == ssfdb_pkg::OFS_FLAGS_AND_RATE);
  assign wr_dat = reg_wr && (reg_addr == ssfdb_pkg::OFS_BYTE_BUFFER);
  assign rd_flg = reg_rd && (reg_addr == ssfdb_pkg::OFS_FLAGS_AND_RATE);
  assign rd_dat = reg_rd && (reg_addr == ssfdb_pkg::OFS_BYTE_BUFFER);

  // master rate: one half period every divisor clocks
  assign divisor = rate_divisor({rate_select_high_r, rate_select_low_r});
  assign tick = master && (st_r == ssfdb_pkg::st_xfer) && (div_r == divisor - 8'h01);

  // slave sees clock edges only while selected
  assign slave_edge = !master && !ss_n_in && (sck_in != sck_prev_r);
  assign slave_start = enable && (st_r == ssfdb_pkg::st_idle) &&
                       (cpha ? (slave_edge && (sck_in != cpol)) : (!ss_n_in && ss_prev_r));
  assign active = (st_r == ssfdb_pkg::st_xfer) || slave_start;
  assign lead = active && (master ? (tick && !phase_r) : (slave_edge && (sck_in != cpol)));
  assign trail = active && (master ? (tick && phase_r) : (slave_edge && (sck_in == cpol)));
  assign done = trail && (cnt_r == ssfdb_pkg::LAST_BIT);

  assign in_bit = master ? miso_in : mosi_in;
  assign byte_in = cpha ? {sh_r[6:0], in_bit} : {sh_r[6:0], rbit_r};

  // busy slave holds the shifter until the byte ends
  assign load = enable && !transmit_empty_flag_r && (st_r == ssfdb_pkg::st_idle) &&
                !slave_start;

  assign fault_slave = enable && !master && (st_r == ssfdb_pkg::st_xfer) &&
                       ss_n_in && !ss_prev_r;
  assign fault_master = enable && master && mode_fault_detect_enable_r && !ss_n_in;
  // without fault detect a master looks at the select pin only at clock phase 0, where a select fall while idle starts a transfer
  assign abort = fault_slave || fault_master;

  // control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_r <= ssfdb_pkg::CTL_RESET;
    end
    else if (wr_ctl)
    begin
      ctl_r <= reg_wdata & ssfdb_pkg::CTL_WMASK;
    end
  end

  // writable bits of the flags and rate register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      error_irq_enable_r <= 1'b0;
      mode_fault_detect_enable_r <= 1'b0;
      rate_select_high_r <= 1'b0;
      rate_select_low_r <= 1'b0;
    end
    else if (wr_flg)
    begin
      error_irq_enable_r <= reg_wdata[ssfdb_pkg::FLG_ERR_IRQ_EN];
      mode_fault_detect_enable_r <= reg_wdata[ssfdb_pkg::FLG_MODE_FAULT_FLAG_EN];
      rate_select_high_r <= reg_wdata[ssfdb_pkg::FLG_RATE_HI];
      rate_select_low_r <= reg_wdata[ssfdb_pkg::FLG_RATE_LO];
    end
  end

  // receive-full flag: a byte completing while the flag is clear wins over a clearing read in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      receive_full_flag_r <= 1'b0;
    end
    else if (done && !receive_full_flag_r)
    begin
      receive_full_flag_r <= 1'b1;
    end
    else if (rd_dat)
    begin
      receive_full_flag_r <= 1'b0;
    end
  end

  // receive register keeps the old byte on overrun
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_r <= 8'h00;
    end
    else if (done && !receive_full_flag_r)
    begin
      rx_r <= byte_in;
    end
  end

  // clear sequences: arm on a status read that saw the flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ovr_arm_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end
    else
    begin
      if (rd_flg)
      begin
        ovr_arm_r <= overrun_flag_r;
      end
      else if (rd_dat)
      begin
        ovr_arm_r <= 1'b0;
      end
      if (rd_flg)
      begin
        mode_fault_flag_arm_r <= mode_fault_flag_r;
      end
      else if (wr_dat)
      begin
        mode_fault_flag_arm_r <= 1'b0;
      end
    end
  end

  // overrun flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      overrun_flag_r <= 1'b0;
    end
    else if (done && receive_full_flag_r)
    begin
      overrun_flag_r <= 1'b1;
    end
    else if (rd_dat && ovr_arm_r)
    begin
      overrun_flag_r <= 1'b0;
    end
  end

  // mode fault flag; the detect enable only gates setting
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_fault_flag_r <= 1'b0;
    end
    else if (abort && mode_fault_detect_enable_r)
    begin
      mode_fault_flag_r <= 1'b1;
    end
    else if (wr_dat && mode_fault_flag_arm_r)
    begin
      mode_fault_flag_r <= 1'b0;
    end
  end

  // transmit register and empty flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_r <= 8'h00;
      transmit_empty_flag_r <= 1'b1;
    end
    else if (load)
    begin
      transmit_empty_flag_r <= 1'b1;
    end
    else if (wr_dat)
    begin
      tx_r <= reg_wdata;
      transmit_empty_flag_r <= 1'b0;
    end
  end

  // transfer state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= ssfdb_pkg::st_idle;
    end
    else if (!enable || abort)
    begin
      st_r <= ssfdb_pkg::st_idle;
    end
    else
    begin
      case (st_r)
        ssfdb_pkg::st_idle:
        begin
          if ((load && master) || slave_start)
          begin
            st_r <= ssfdb_pkg::st_xfer;
          end
        end
        ssfdb_pkg::st_xfer:
        begin
          if (done)
          begin
            st_r <= ssfdb_pkg::st_idle;
          end
        end
        default:
        begin
          st_r <= ssfdb_pkg::st_idle;
        end
      endcase
    end
  end

  // shift register, bit count and line bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      rbit_r <= 1'b0;
      out_r <= 1'b0;
    end
    else if (load)
    begin
      sh_r <= tx_r;
      cnt_r <= 3'h0;
      out_r <= tx_r[7];
    end
    else if (!enable || abort)
    begin
      cnt_r <= 3'h0;
    end
    else if (lead)
    begin
      if (cpha)
      begin
        out_r <= sh_r[7];
      end
      else
      begin
        rbit_r <= in_bit;
      end
    end
    else if (trail)
    begin
      sh_r <= byte_in;
      cnt_r <= cnt_r + 3'h1;
      if (!cpha)
      begin
        out_r <= sh_r[6];
      end
    end
  end

  // master clock generation
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_r <= 8'h00;
      phase_r <= 1'b0;
    end
    else if (st_r != ssfdb_pkg::st_xfer || !master)
    begin
      div_r <= 8'h00;
      phase_r <= 1'b0;
    end
    else if (tick)
    begin
      div_r <= 8'h00;
      phase_r <= !phase_r;
    end
    else
    begin
      div_r <= div_r + 8'h01;
    end
  end

  // serial clock level; idle level follows polarity
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sck_r <= 1'b0;
    end
    else if (tick)
    begin
      sck_r <= cpol ^ !phase_r;
    end
    else if (st_r != ssfdb_pkg::st_xfer)
    begin
      sck_r <= cpol;
    end
  end

  // pin history for slave edges and select edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sck_prev_r <= 1'b0;
      ss_prev_r <= 1'b1;
    end
    else
    begin
      sck_prev_r <= sck_in;
      ss_prev_r <= ss_n_in;
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        ssfdb_pkg::OFS_CONTROL: reg_rdata <= ctl_r;
        ssfdb_pkg::OFS_FLAGS_AND_RATE: reg_rdata <= {receive_full_flag_r,
          error_irq_enable_r, overrun_flag_r, mode_fault_flag_r, transmit_empty_flag_r,
          mode_fault_detect_enable_r, rate_select_high_r, rate_select_low_r};
        ssfdb_pkg::OFS_BYTE_BUFFER: reg_rdata <= rx_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // requests are levels that follow flag and enable
  assign irq_receive = receive_full_flag_r && ctl_r[ssfdb_pkg::CTL_RX_IRQ_EN];
  assign irq_transmit = transmit_empty_flag_r && ctl_r[ssfdb_pkg::CTL_TX_IRQ_EN];
  assign irq_error = error_irq_enable_r && (overrun_flag_r || mode_fault_flag_r);

  // pin drivers; enables are active low
  assign sck_out = sck_r;
  assign mosi_out = out_r;
  assign miso_out = out_r;
  assign sck_oe_n = !(enable && master);
  assign mosi_oe_n = !(enable && master);
  assign miso_oe_n = !(enable && !master && !ss_n_in);
  // an enabled slave always keeps the select pin as its input
  assign ss_gpio_release = !(enable && (!master || mode_fault_detect_enable_r));

endmodule

// [tb/ssfdb_props.sv]
// Purpose: port checker for the serial flags block
// Assumes: shadow of writable bits follows software writes
// Notes: bound to ssfdb_top
`timescale 1ns/1ps
module ssfdb_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests and pins
  input wire logic irq_receive,
  input wire logic irq_transmit,
  input wire logic irq_error,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic ss_n_in,
  input wire logic ss_gpio_release
);
  logic [7:0] ctl_r;
  logic [7:0] flg_r;
  logic en_m;
  logic en_s;
  logic wr_buf;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_r <= ssfdb_pkg::CTL_RESET;
      flg_r <= 8'h00;
    end
    else if (reg_wr && reg_addr == ssfdb_pkg::OFS_CONTROL)
      ctl_r <= reg_wdata & ssfdb_pkg::CTL_WMASK;
    else if (reg_wr && reg_addr == ssfdb_pkg::OFS_FLAGS_AND_RATE)
      flg_r <= reg_wdata & 8'h47;
  end
  assign en_m = ctl_r[1] && ctl_r[5];
  assign en_s = ctl_r[1] && !ctl_r[5];
  assign wr_buf = reg_wr && reg_addr == ssfdb_pkg::OFS_BYTE_BUFFER;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_rx_gate: assert property (!ctl_r[7] |-> !irq_receive)
    else $error("receive request without enable");
  a_tx_gate: assert property (!ctl_r[0] |-> !irq_transmit)
    else $error("transmit request without enable");
  a_err_gate: assert property (!flg_r[6] |-> !irq_error)
    else $error("error request without enable");
  a_master_pins: assert property (en_m |-> !sck_oe_n && !mosi_oe_n && miso_oe_n)
    else $error("master pin directions wrong");
  a_select_release: assert property (ss_gpio_release == !(ctl_r[1] && (!ctl_r[5] || flg_r[2])))
    else $error("select pin release wrong");
  a_slave_miso: assert property (miso_oe_n == !(en_s && !ss_n_in))
    else $error("slave output enable wrong");
  a_rate_hold: assert property ($rose(sck_out) && en_m && flg_r[1:0] == 2'h1 |=> $stable(sck_out)[*7])
    else $error("serial clock half period short");
  a_read_clears: assert property (reg_rd && reg_addr == ssfdb_pkg::OFS_BYTE_BUFFER && ctl_r[7] |=> !irq_receive)
    else $error("data read kept receive full");
  a_write_refill: assert property (wr_buf && en_m && ctl_r[0] && irq_transmit |=> !irq_transmit ##1 irq_transmit)
    else $error("transmit empty not back in two cycles");
endmodule
bind ssfdb_top ssfdb_props i_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_receive(irq_receive), .irq_transmit(irq_transmit), .irq_error(irq_error),
  .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
  .ss_n_in(ss_n_in), .ss_gpio_release(ss_gpio_release));

// [tb/ssfdb_peer.sv]
// Purpose: peer serial slave facing the block in master mode
// Assumes: clock phase 1, clock idles low
// Notes: serial clock seen through clk samples only
`timescale 1ns/1ps
module ssfdb_peer (
  // clock
  input wire logic clk,
  // load side
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  logic sck_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  initial miso = 1'b0;
  always @(posedge clk)
  begin
    sck_r <= sck;
    if (load)
    begin
      sh_r <= tx_byte;
      cnt_r <= 4'h0;
    end
    else if (sck && !sck_r)
    begin
      miso <= sh_r[7];
      sh_r <= {sh_r[6:0], 1'b0};
    end
    else if (!sck && sck_r)
    begin
      rx_byte <= {rx_byte[6:0], mosi};
      cnt_r <= cnt_r + 4'h1;
      // line inverted after the byte: the last bit does not stay on it
      if (cnt_r == 4'h7)
        miso <= ~miso;
    end
  end
endmodule

// [tb/ssfdb_top_tb.sv]
// Purpose: register-level test of the serial flags block as master
// Assumes: peer slave model on the serial pins
// Notes: slave transfers are not driven; the checker covers only the slave output enable and the select pin release
`timescale 1ns/1ps
module ssfdb_top_tb;
  localparam logic [7:0] CTL = ssfdb_pkg::OFS_CONTROL;
  localparam logic [7:0] FLG = ssfdb_pkg::OFS_FLAGS_AND_RATE;
  localparam logic [7:0] BUF = ssfdb_pkg::OFS_BYTE_BUFFER;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ss_n_in = 1'b1;
  logic p_load = 1'b0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] p_rx;
  logic irq_receive, irq_transmit, irq_error, sck_out, mosi_out, miso_line, ss_gpio_release;
  logic sck_last = 1'b0;
  logic [7:0] divs [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
  int n_errors = 0;
  int num_checks = 0;
  int edges = 0;
  int hp = 0;
  int tick = 0;
  always #20 clk = ~clk;
  ssfdb_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_receive(irq_receive),
    .irq_transmit(irq_transmit), .irq_error(irq_error), .sck_in(1'b0), .sck_out(sck_out),
    .sck_oe_n(), .mosi_in(1'b0), .mosi_out(mosi_out), .mosi_oe_n(), .miso_in(miso_line),
    .miso_out(), .miso_oe_n(), .ss_n_in(ss_n_in), .ss_gpio_release(ss_gpio_release));
  ssfdb_peer i_peer (.clk(clk), .load(p_load), .tx_byte(p_tx), .rx_byte(p_rx),
    .sck(sck_out), .mosi(mosi_out), .miso(miso_line));
  // spacing of serial clock toggles, in clk cycles
  always @(posedge clk)
  begin
    tick++;
    if (sck_out !== sck_last)
    begin
      hp = tick;
      tick = 0;
      edges++;
      sck_last = sck_out;
    end
  end
  task automatic results;
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  task automatic xfer(input logic [7:0] mine, input logic [7:0] peer);
    @(posedge clk);
    p_tx <= peer;
    p_load <= 1'b1;
    @(posedge clk);
    p_load <= 1'b0;
    edges = 0;
    wr(BUF, mine);
    #1;
    chk("tx_busy", 8'h00, {7'h00, irq_transmit});
    repeat (2) @(posedge clk);
    #1;
    chk("tx_empty", 8'h01, {7'h00, irq_transmit});
    for (int i = 0; i < 5000 && edges < 16; i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
    chk("clock_edges", 8'h10, edges[7:0]);
  endtask
  task automatic drop_select;
    @(posedge clk);
    ss_n_in <= 1'b0;
    repeat (4) @(posedge clk);
    ss_n_in <= 1'b1;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("control", CTL, 8'h28);
    rd_chk("flags", FLG, 8'h08);
    wr(8'h13, 8'hFF);
    rd_chk("unmapped", 8'h13, 8'h00);
    wr(FLG, 8'hFF);
    rd_chk("flags_rw", FLG, 8'h4F);
    wr(CTL, 8'hAB);
    for (int c = 0; c < 4; c++)
    begin
      wr(FLG, {6'h00, c[1:0]});
      xfer(8'hA5 ^ c[7:0], 8'h3C + c[7:0]);
      chk("half_period", divs[c], hp[7:0]);
      chk("peer_rx", 8'hA5 ^ c[7:0], p_rx);
      chk("irq_rx", 8'h01, {7'h00, irq_receive});
      rd_chk("rx_data", BUF, 8'h3C + c[7:0]);
      chk("irq_rx_clr", 8'h00, {7'h00, irq_receive});
    end
    // no read-modify-write on the buffer anywhere below
    wr(FLG, 8'h40);
    xfer(8'h81, 8'h11);
    xfer(8'h82, 8'h22);
    chk("irq_err", 8'h01, {7'h00, irq_error});
    rd_chk("flags_ovr", FLG, 8'hE8);
    rd_chk("rx_kept", BUF, 8'h11);
    rd_chk("flags_clr", FLG, 8'h48);
    drop_select();
    rd_chk("no_fault", FLG, 8'h48);
    wr(FLG, 8'h44);
    #1;
    chk("ss_dedicated", 8'h00, {7'h00, ss_gpio_release});
    drop_select();
    rd_chk("fault", FLG, 8'h5C);
    chk("irq_fault", 8'h01, {7'h00, irq_error});
    wr(FLG, 8'h40);
    rd_chk("fault_kept", FLG, 8'h58);
    chk("ss_free", 8'h01, {7'h00, ss_gpio_release});
    xfer(8'h5A, 8'h66);
    rd_chk("fault_clr", FLG, 8'hC8);
    chk("irq_err_clr", 8'h00, {7'h00, irq_error});
    rd_chk("rx_last", BUF, 8'h66);
    results();
  end
endmodule
